/* include/slcr_pkg.sv */
package slcr_pkg;
    localparam logic [7:0] SLCR_ADDR_GENERAL   = 8'h03;
    localparam logic [7:0] SLCR_ADDR_MODE      = 8'h04;
    localparam logic [7:0] SLCR_GENERAL_RESET  = 8'hD2;
    localparam logic [7:0] SLCR_MODE_RESET     = 8'h80;
    localparam logic [7:0] SLCR_GENERAL_MASK   = 8'hBA;
    localparam logic [7:0] SLCR_MODE_MASK      = 8'hB0;
    localparam int         SLCR_CRC_EN_BIT     = 7;
    localparam int         SLCR_AUTO_ACK_BIT   = 5;
    localparam int         SLCR_FILTER_BIT     = 4;
    localparam int         SLCR_PASS_BIT       = 3;
    localparam int         SLCR_CLK_AUTO_BIT   = 1;
    localparam int         SLCR_FAILSAFE_BIT   = 7;
    localparam int         SLCR_CRC_CLEAR_BIT  = 5;
    localparam int         SLCR_VIDEO_GATE_BIT = 4;
    localparam int         SLCR_FILTER_CYCLES  = 2;
endpackage

/* rtl/slcr_glitch_filter.sv */
`timescale 1ns/1ns
module slcr_glitch_filter
    import slcr_pkg::*;
(
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic enable,
    input  wire logic raw,
    output logic      filtered
);
    logic [1:0] count;

    // A new level must persist for two full clocks before it is passed on.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count    <= 2'h0;
            filtered <= 1'b0;
        end else if (!enable || raw == filtered) begin
            count    <= 2'h0;
            filtered <= enable ? filtered : raw;
        end else if (count == 2'(SLCR_FILTER_CYCLES - 1)) begin
            count    <= 2'h0;
            filtered <= raw;
        end else begin
            count <= count + 2'h1;
        end
    end
endmodule

/* rtl/slcr_config_regs.sv */
`timescale 1ns/1ns
module slcr_config_regs
    import slcr_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       reg_write,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       crc_error_in,
    output logic      [7:0] crc_error_count,
    output logic            crc_check_enable,
    input  wire logic       i2c_write_start,
    input  wire logic       i2c_target_is_des,
    input  wire logic       i2c_forward_all,
    input  wire logic       remote_nack,
    output logic            local_ack,
    output logic            local_nack,
    input  wire logic [6:0] i2c_address,
    input  wire logic [6:0] remote_target_alias,
    input  wire logic [6:0] remote_target_id,
    output logic            forward_hit,
    output logic      [6:0] forward_address,
    input  wire logic       de_in,
    input  wire logic       hs_in,
    input  wire logic       vs_in,
    input  wire logic       inputs_lost,
    output logic            de_out,
    output logic            hs_out,
    output logic            vs_out,
    output logic            link_clock_automatic_select,
    output logic            video_gate
);
    logic [7:0] general_cfg;
    logic [7:0] mode_cfg;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] filt;
    logic       fail_level;
    logic       write_general;
    logic       write_mode;

    // The address decode is shared by the write path and the read path.
    function automatic logic addr_is(
        input logic [7:0] addr,
        input logic [7:0] target
    );
        return addr == target;
    endfunction

    // Unmapped addresses read zero so software can probe the map safely.
    function automatic logic [7:0] read_value(
        input logic [7:0] addr,
        input logic [7:0] general,
        input logic [7:0] mode
    );
        logic [7:0] value;
        value = 8'h00;
        if (addr_is(addr, SLCR_ADDR_GENERAL)) begin
            value = general;
        end else if (addr_is(addr, SLCR_ADDR_MODE)) begin
            value = mode;
        end
        return value;
    endfunction

    // A lost input shows the failsafe level instead of a floating value.
    function automatic logic pick_level(
        input logic lost,
        input logic level,
        input logic pin
    );
        return lost ? level : pin;
    endfunction

    assign write_general = reg_write && addr_is(reg_addr, SLCR_ADDR_GENERAL);
    assign write_mode    = reg_write && addr_is(reg_addr, SLCR_ADDR_MODE);

    // Reserved bits are masked off on write, so they read zero once written; the general reset value leaves bit 6 set.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            general_cfg <= SLCR_GENERAL_RESET;
        end else if (write_general) begin
            general_cfg <= reg_wdata & SLCR_GENERAL_MASK;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mode_cfg <= SLCR_MODE_RESET;
        end else if (write_mode) begin
            mode_cfg <= reg_wdata & SLCR_MODE_MASK;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= read_value(reg_addr, general_cfg, mode_cfg);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            crc_check_enable <= 1'b1;
        end else begin
            crc_check_enable <= general_cfg[SLCR_CRC_EN_BIT];
        end
    end

    // The clear bit holds the counter at zero for as long as it stays set.
    // The counter saturates so a long error burst cannot wrap back to a small value.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            crc_error_count <= 8'h00;
        end else if (mode_cfg[SLCR_CRC_CLEAR_BIT]) begin
            crc_error_count <= 8'h00;
        end else if (general_cfg[SLCR_CRC_EN_BIT] && crc_error_in
                     && crc_error_count != 8'hFF) begin
            crc_error_count <= crc_error_count + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            local_ack  <= 1'b0;
            local_nack <= 1'b0;
        end else begin
            local_ack  <= i2c_write_start && general_cfg[SLCR_AUTO_ACK_BIT]
                          && (i2c_target_is_des || i2c_forward_all);
            local_nack <= remote_nack && !general_cfg[SLCR_AUTO_ACK_BIT];
        end
    end

    // A zero alias disables the entry, so address zero never matches.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            forward_hit <= 1'b0;
        end else begin
            forward_hit <= general_cfg[SLCR_PASS_BIT] && remote_target_alias != 7'h00
                           && i2c_address == remote_target_alias;
        end
    end

    // The remap runs even with pass-through off; only the hit flag gates forwarding.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            forward_address <= 7'h00;
        end else begin
            forward_address <= (i2c_address == remote_target_alias)
                               ? remote_target_id : i2c_address;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
        end else begin
            sync1 <= {de_in, hs_in, vs_in};
            sync2 <= sync1;
        end
    end

    for (genvar i = 0; i < 3; i++) begin : g_filt
        slcr_glitch_filter u_filt (
            .mclk     (mclk),
            .reset_n  (reset_n),
            .enable   (general_cfg[SLCR_FILTER_BIT]),
            .raw      (sync2[i]),
            .filtered (filt[i])
        );
    end

    assign fail_level = !mode_cfg[SLCR_FAILSAFE_BIT];

    // Lost inputs are forced to the failsafe level rather than left floating.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            de_out <= 1'b0;
        end else begin
            de_out <= pick_level(inputs_lost, fail_level, filt[2]);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hs_out <= 1'b0;
        end else begin
            hs_out <= pick_level(inputs_lost, fail_level, filt[1]);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            vs_out <= 1'b0;
        end else begin
            vs_out <= pick_level(inputs_lost, fail_level, filt[0]);
        end
    end

    // These bits only steer logic outside this block, so they are stored as they are.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            link_clock_automatic_select <= 1'b1;
        end else begin
            link_clock_automatic_select <= general_cfg[SLCR_CLK_AUTO_BIT];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            video_gate <= 1'b0;
        end else begin
            video_gate <= mode_cfg[SLCR_VIDEO_GATE_BIT];
        end
    end
endmodule

/* verif/slcr_chk.sv */
`timescale 1ns/1ns
module slcr_chk
    import slcr_pkg::*;
(
    input wire logic       mclk,
    input wire logic       reset_n,
    input wire logic       reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       crc_error_in,
    input wire logic [7:0] crc_error_count,
    input wire logic       crc_check_enable,
    input wire logic       i2c_write_start,
    input wire logic       i2c_target_is_des,
    input wire logic       i2c_forward_all,
    input wire logic       remote_nack,
    input wire logic       local_ack,
    input wire logic       local_nack,
    input wire logic       forward_hit
);
    // Shadow copies of the control bits, updated on the same edge as the registers.
    logic en, aa, pass, clr;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {en, aa, pass, clr} <= 4'h8;
        end else if (reg_write && reg_addr == SLCR_ADDR_GENERAL) begin
            {en, aa, pass} <= {reg_wdata[7], reg_wdata[5], reg_wdata[3]};
        end else if (reg_write && reg_addr == SLCR_ADDR_MODE) begin
            clr <= reg_wdata[5];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    crc_enable_a: assert property (reg_write && reg_addr == SLCR_ADDR_GENERAL
        |-> ##2 crc_check_enable == $past(reg_wdata[7], 2)) else $error("crc enable");
    ack_given_a: assert property (i2c_write_start && aa
        && (i2c_target_is_des || i2c_forward_all) |=> local_ack) else $error("no ack");
    ack_held_a: assert property (i2c_write_start && !(aa
        && (i2c_target_is_des || i2c_forward_all)) |=> !local_ack) else $error("early ack");
    nack_block_a: assert property (remote_nack && aa |=> !local_nack)
        else $error("nack leaked");
    nack_pass_a: assert property (remote_nack && !aa |=> local_nack)
        else $error("nack lost");
    fwd_off_a: assert property (!pass |=> !forward_hit) else $error("forward off");
    crc_clear_a: assert property (clr |=> crc_error_count == 8'h00)
        else $error("count not cleared");
    crc_count_a: assert property (crc_error_in && en && !clr
        && crc_error_count != 8'hFF |=> crc_error_count == $past(crc_error_count) + 8'h01)
        else $error("count step");
endmodule

/* verif/slcr_partner.sv */
`timescale 1ns/1ns
module slcr_partner #(
    parameter int DELAY = 3
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic i2c_write_start,
    input  wire logic nack_en,
    output logic      remote_nack
);
    // The far side answers late, so an early local acknowledge cannot lean on it.
    logic [DELAY-1:0] pipe;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pipe <= '0;
        end else begin
            pipe <= {pipe[DELAY-2:0], i2c_write_start & nack_en};
        end
    end
    assign remote_nack = pipe[DELAY-1];
endmodule

/* verif/tb.sv */
`timescale 1ns/1ns
module tb;
    import slcr_pkg::*;
    logic       mclk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, crc_error_in = 1'b0;
    logic       i2c_write_start = 1'b0, i2c_target_is_des = 1'b0, i2c_forward_all = 1'b0;
    logic       de_in = 1'b1, hs_in = 1'b1, vs_in = 1'b1, inputs_lost = 1'b1, nack_en = 1'b1;
    logic       remote_nack, local_ack, local_nack, forward_hit, crc_check_enable, mark;
    logic       de_out, hs_out, vs_out, link_clock_automatic_select, video_gate;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, crc_error_count;
    logic [6:0] i2c_address = 7'h21, remote_target_alias = 7'h21, remote_target_id = 7'h50;
    logic [6:0] forward_address;
    int         bad_count = 0, total_checks = 0;
    always #5 mclk = ~mclk;
    slcr_config_regs dut (.*);
    slcr_partner rdes (.mclk, .reset_n, .i2c_write_start, .nack_en, .remote_nack);
    task automatic t(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        t(1);
        reg_write = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        t(2);
        chk(reg_rdata, e);
    endtask
    task automatic pulse(ref logic s);
        s = ~s;
        t(1);
        s = ~s;
    endtask
    task automatic watch(ref logic s, input logic v);
        mark = 1'b0;
        repeat (8) begin
            t(1);
            if (s === v) mark = 1'b1;
        end
    endtask
    task automatic finish_test;
        $display("Checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        t(5000);
        bad_count++;
        finish_test;
    end
    initial begin
        t(16);
        reset_n = 1'b1;
        rd(SLCR_ADDR_GENERAL, 8'hD2);
        rd(SLCR_ADDR_MODE, 8'h80);
        chk({6'h00, link_clock_automatic_select, video_gate}, 8'h02);
        chk({5'h00, de_out, hs_out, vs_out}, 8'h00);
        rd(8'h05, 8'h00);
        wr(SLCR_ADDR_GENERAL, 8'hFF);
        rd(SLCR_ADDR_GENERAL, 8'hBA);
        wr(SLCR_ADDR_MODE, 8'h7F);
        rd(SLCR_ADDR_MODE, 8'h30);
        chk({6'h00, link_clock_automatic_select, video_gate}, 8'h03);
        chk({5'h00, de_out, hs_out, vs_out}, 8'h07);
        repeat (2) pulse(crc_error_in);
        chk(crc_error_count, 8'h00);
        wr(SLCR_ADDR_MODE, 8'h00);
        repeat (3) pulse(crc_error_in);
        chk(crc_error_count, 8'h03);
        wr(SLCR_ADDR_GENERAL, 8'h3A);
        t(2);
        pulse(crc_error_in);
        chk(crc_error_count, 8'h03);
        inputs_lost = 1'b0;
        for (int f = 0; f < 2; f++) begin
            wr(SLCR_ADDR_GENERAL, f ? 8'hA2 : 8'hB2);
            t(8);
            pulse(de_in);
            watch(de_out, 1'b0);
            chk({7'h00, mark}, {7'h00, f == 1});
        end
        for (int k = 0; k < 4; k++) begin
            {i2c_target_is_des, i2c_forward_all} = 2'(k);
            pulse(i2c_write_start);
            chk({7'h00, local_ack}, {7'h00, k != 0});
            watch(local_nack, 1'b1);
            chk({7'h00, mark}, 8'h00);
        end
        wr(SLCR_ADDR_GENERAL, 8'h8A);
        pulse(i2c_write_start);
        chk({7'h00, local_ack}, 8'h00);
        watch(local_nack, 1'b1);
        chk({7'h00, mark}, 8'h01);
        chk({1'b0, forward_address}, 8'h50);
        chk({7'h00, forward_hit}, 8'h01);
        i2c_address = 7'h22;
        t(2);
        chk({1'b0, forward_address}, 8'h22);
        chk({7'h00, forward_hit}, 8'h00);
        wr(SLCR_ADDR_GENERAL, 8'h00);
        t(2);
        chk({6'h00, link_clock_automatic_select, video_gate}, 8'h00);
        finish_test;
    end
endmodule
bind slcr_config_regs slcr_chk chk_i (.*);
